/* dv/debug_host_model.sv */
// Behavioural debug host that issues one command and collects its answer.
`timescale 1ns/1ps
module debug_host_model (
    // Clock.
    input wire logic clk_i,
    // Command request and answer.
    output logic cmd_valid_o,
    output logic [2:0] cmd_code_o,
    input wire logic cmd_done_i,
    input wire logic cmd_error_i
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 3'h0;
    end
    // The code is inverted once valid drops, so a design that reads it late sees garbage.
    task automatic send(input logic [2:0] c, output logic d, output logic e);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= c;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~c;
        @(posedge clk_i);
        d = cmd_done_i;
        e = cmd_error_i;
    endtask
endmodule

/* dv/tb_top.sv */
// Self-checking testbench for the operating mode sequencer.
`timescale 1ns/1ps
module tb_top;
    import opmode_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, rst_pin_n_i = 1'b1, mode_select_debug_pin_i = 1'b1, ext_interrupt_pin_i = 1'b1;
    logic slow_osc_tick_i = 1'b0, halt_instr_i = 1'b0, debug_halt_instr_i = 1'b0;
    logic ctrl_bkpt_i = 1'b0, trig_bkpt_i = 1'b0, lvd_irq_i = 1'b0, adc_irq_i = 1'b0;
    logic serial_irq_i = 1'b0, cmd_valid_i, cmd_done_o, cmd_error_o, trace_step_o;
    logic [2:0] cmd_code_i;
    logic [15:0] port_value_i = 16'hA5C3, vector_o, pins_o;
    logic cpu_run_o, cpu_suspend_o, periph_reset_o, reset_fetch_o, int_wake_o;
    logic illegal_reset_o, clocks_halt_o, debug_clk_keep_o, logic_power_off_o;
    logic regulator_standby_o, clk_gen_off_o, osc_keep_o, adc_disable_o, wake_osc_en_o;
    logic pin_latch_o, d, e, iw_seen = 1'b0, ill_seen = 1'b0;
    int fails = 0, n_tests = 0;
    operating_mode_sequencer #(.PINS(16)) dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rst_pin_n_i, .mode_select_debug_pin_i,
        .ext_interrupt_pin_i, .slow_osc_tick_i, .halt_instr_i, .debug_halt_instr_i,
        .ctrl_bkpt_i, .trig_bkpt_i, .lvd_irq_i, .adc_irq_i, .serial_irq_i, .port_value_i,
        .cmd_valid_i, .cmd_code_i, .cmd_done_o, .cmd_error_o, .trace_step_o, .cpu_run_o,
        .cpu_suspend_o, .periph_reset_o, .reset_fetch_o, .vector_o, .int_wake_o,
        .illegal_reset_o, .clocks_halt_o, .debug_clk_keep_o, .logic_power_off_o,
        .regulator_standby_o, .clk_gen_off_o, .osc_keep_o, .adc_disable_o,
        .wake_osc_en_o, .pin_latch_o, .pins_o);
    debug_host_model host_u (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
        .cmd_code_o(cmd_code_i), .cmd_done_i(cmd_done_o), .cmd_error_i(cmd_error_o));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Event pulses last one cycle, so they are caught here rather than by polling.
    always @(posedge clk_i) begin
        if (int_wake_o === 1'b1) iw_seen <= 1'b1;
        if (illegal_reset_o === 1'b1) ill_seen <= 1'b1;
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= wd;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        dat_i <= ~wd;
        if (n >= 50) begin
            chk("bus answer", 1, 0);
            results();
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return cpu_run_o;
            1: return cpu_suspend_o;
            default: return clocks_halt_o;
        endcase
    endfunction
    task automatic wait_sig(input int k);
        int n;
        n = 0;
        while (sig(k) !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 300) begin
            chk("mode wait", k, 32'hFF);
            results();
        end
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        if (k == 1) halt_instr_i <= 1'b1;
        else debug_halt_instr_i <= 1'b1;
        @(posedge clk_i);
        halt_instr_i <= 1'b0;
        debug_halt_instr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_boot;
        wait_sig(0);
        chk("reset fetch", 1, reset_fetch_o);
        chk("vector", 16'hFFFE, vector_o);
        wb(1'b0, ADDR_STAT, 32'h0);
        chk("stat mode", 32'h1, {29'h0, q[2:0]});
        wb(1'b0, 8'hFC, 32'h0);
        chk("unmapped read", 32'h0, q);
    endtask
    task automatic t_debug;
        host_u.send(CMD_CPU_REG, d, e);
        chk("cpu reg in run", 2'b11, {d, e});
        host_u.send(CMD_MEM_STAT, d, e);
        chk("mem status in run", 2'b10, {d, e});
        host_u.send(CMD_SPARE, d, e);
        chk("spare", 2'b11, {d, e});
        pulse(0);
        wait_sig(1);
        chk("run in debug", 0, cpu_run_o);
        host_u.send(CMD_TRACE, d, e);
        chk("trace in debug", 3'b101, {d, e, trace_step_o});
        host_u.send(CMD_CTRL_REG, d, e);
        chk("ctrl reg in debug", 2'b10, {d, e});
        host_u.send(CMD_GO, d, e);
        chk("go run", 3'b101, {d, e, cpu_run_o});
        host_u.send(CMD_BACKGROUND, d, e);
        wait_sig(1);
        chk("background", 3'b100, {d, e, cpu_run_o});
        host_u.send(CMD_MEM, d, e);
        host_u.send(CMD_GO, d, e);
        wait_sig(0);
    endtask
    task automatic t_illegal;
        wb(1'b1, ADDR_OPT, 32'h0);
        pulse(1);
        wait_sig(0);
        chk("illegal reset", 2'b10, {ill_seen, clocks_halt_o});
    endtask
    task automatic t_pin;
        mode_select_debug_pin_i <= 1'b0;
        rst_pin_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("pin reset", 2'b10, {periph_reset_o, cpu_run_o});
        rst_pin_n_i <= 1'b1;
        wait_sig(1);
        chk("pin debug entry", 2'b01, {cpu_run_o, cpu_suspend_o});
        mode_select_debug_pin_i <= 1'b1;
        host_u.send(CMD_GO, d, e);
        wait_sig(0);
    endtask
    task automatic t_stop(input logic [31:0] opt, input logic ppd, input logic deep);
        wb(1'b1, ADDR_OPT, opt);
        wb(1'b1, ADDR_PMC2, {31'h0, ppd});
        pulse(1);
        wait_sig(2);
        chk("power off", deep, logic_power_off_o);
        chk("regulator", deep | !(opt[1] & opt[2] | opt[3]), regulator_standby_o);
        chk("clock gen off", deep | !(opt[3] | opt[4]), clk_gen_off_o);
        chk("adc off", deep, adc_disable_o);
        chk("osc keep", !deep & (opt[3] | opt[4]), osc_keep_o);
        chk("debug clocks", !deep & opt[3], debug_clk_keep_o);
    endtask
    task automatic t_light;
        t_stop(32'h1, 1'b0, 1'b0);
        iw_seen = 1'b0;
        adc_irq_i <= 1'b1;
        wait_sig(0);
        adc_irq_i <= 1'b0;
        @(posedge clk_i);
        chk("light wake", 2'b10, {iw_seen, pin_latch_o});
        t_stop(32'h101, 1'b0, 1'b0);
        chk("wake osc", 1, wake_osc_en_o);
        iw_seen = 1'b0;
        repeat (8) begin
            slow_osc_tick_i <= 1'b1;
            @(posedge clk_i);
            slow_osc_tick_i <= 1'b0;
            @(posedge clk_i);
        end
        wait_sig(0);
        @(posedge clk_i);
        chk("timer wake", 1, iw_seen);
        t_stop(32'h7, 1'b1, 1'b0);
        adc_irq_i <= 1'b1;
        wait_sig(0);
        adc_irq_i <= 1'b0;
        t_stop(32'h9, 1'b1, 1'b0);
        host_u.send(CMD_BACKGROUND, d, e);
        wait_sig(1);
        chk("background wake", 2'b10, {d, e});
        host_u.send(CMD_GO, d, e);
        wait_sig(0);
    endtask
    task automatic t_deep;
        port_value_i <= 16'hA5C3;
        t_stop(32'h1, 1'b1, 1'b1);
        repeat (2) @(posedge clk_i);
        chk("latch", 1, pin_latch_o);
        port_value_i <= 16'h5A3C;
        ext_interrupt_pin_i <= 1'b0;
        wait_sig(0);
        ext_interrupt_pin_i <= 1'b1;
        chk("held pins", 16'hA5C3, pins_o);
        wb(1'b0, ADDR_PMC2, 32'h0);
        chk("wake flag", 32'h8, q);
        wb(1'b1, ADDR_PMC2, 32'h0);
        wb(1'b0, ADDR_PMC2, 32'h0);
        chk("ack zero", {1'b1, 16'hA5C3}, {q[3], pins_o});
        wb(1'b1, ADDR_PMC2, 32'h2);
        repeat (3) @(posedge clk_i);
        chk("open pins", {1'b0, 16'h5A3C}, {pin_latch_o, pins_o});
        wb(1'b0, ADDR_PMC2, 32'h0);
        chk("flag cleared", 32'h0, q);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_debug();
        t_illegal();
        t_pin();
        t_light();
        t_deep();
        results();
    end
endmodule

/* verilog/operating_mode_sequencer.sv */
// Operating mode sequencer: run, debug, deep stop and light stop control.
// Notes on behaviour
// R1 - Mode pin high at reset release: run, vector
// R2 - Five events enter active debug mode
// R3 - Debug mode suspends application instruction execution
// R4 - Non-intrusive commands accepted in run and debug
// R5 - Active commands only execute in debug mode
// R6 - Permitted halt enters stop, clocks halted
// R7 - Unpermitted halt forces illegal-opcode reset
// R8 - Only deep and light stop exist
// R9 - Powerdown select one deep, zero light
// R10 - Deep stop powers off logic, regulator standby
// R11 - Light stop keeps standby, optional oscillator
// R12 - Low-voltage detect in halt forces light stop
// R13 - Deep stop latches pins until acknowledge
// R14 - Deep stop exits on reset, pin, timer
// R15 - Deep wake restarts as power-on reset
// R16 - Wake flag set until acknowledge written
// R17 - Opened latches drive current port values
// R18 - Software restores ports before acknowledging
// R19 - Light stop exits on reset or interrupts
// R20 - Zero wake period disables timer and oscillator
// R21 - Debug enable keeps clocks, deep becomes light
// R22 - Acknowledge zero or unlatched has no effect
`timescale 1ns/1ps
module operating_mode_sequencer
    import opmode_pkg::*;
#(
    parameter int PINS = 16
) (
    // Clock and bus reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device pins.
    input wire logic rst_pin_n_i,
    input wire logic mode_select_debug_pin_i,
    input wire logic ext_interrupt_pin_i,
    input wire logic slow_osc_tick_i,
    // CPU events and port register values.
    input wire logic halt_instr_i,
    input wire logic debug_halt_instr_i,
    input wire logic ctrl_bkpt_i,
    input wire logic trig_bkpt_i,
    input wire logic lvd_irq_i,
    input wire logic adc_irq_i,
    input wire logic serial_irq_i,
    input wire logic [PINS-1:0] port_value_i,
    // Debug command port.
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_code_i,
    output logic cmd_done_o,
    output logic cmd_error_o,
    output logic trace_step_o,
    // CPU control.
    output logic cpu_run_o,
    output logic cpu_suspend_o,
    output logic periph_reset_o,
    output logic reset_fetch_o,
    output logic [15:0] vector_o,
    output logic int_wake_o,
    output logic illegal_reset_o,
    // Power control and pins.
    output logic clocks_halt_o,
    output logic debug_clk_keep_o,
    output logic logic_power_off_o,
    output logic regulator_standby_o,
    output logic clk_gen_off_o,
    output logic osc_keep_o,
    output logic adc_disable_o,
    output logic wake_osc_en_o,
    output logic pin_latch_o,
    output logic [PINS-1:0] pins_o
);
    mode_t mode_q, mode_d;
    cmd_t cmd;
    logic rst_pin_s, ms_pin_s, irq_pin_s, tick_s, tick_q;
    logic [7:0] opt_q;
    logic [WPS_W-1:0] wps_q;
    logic ppd_q, flag_q, latch_q;
    logic [WAKE_TICK_W-1:0] tick_cnt_q;
    logic rti_hit, sys_reset, wr_pmc2, ack_one;
    logic permit, lvd_hold, dbg_en, to_deep, dbg_req, irq_active;
    logic cmd_ok, cmd_bg, cmd_go, illegal_d, intwake_d;

    pin_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(rst_pin_n_i),
        .q_o(rst_pin_s)
    );
    pin_sync #(.W(3), .RST_VAL(3'h7)) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({mode_select_debug_pin_i, ext_interrupt_pin_i, slow_osc_tick_i}),
        .q_o({ms_pin_s, irq_pin_s, tick_s})
    );

    assign cmd = cmd_t'(cmd_code_i);
    assign permit = opt_q[OPT_PERMIT_BIT];
    assign lvd_hold = opt_q[OPT_LOWVOLT_DETECT_EN_BIT] & opt_q[OPT_LOWVOLT_IN_HALT_EN_BIT];
    assign dbg_en = opt_q[OPT_DBGEN_BIT];
    // Deep stop needs the select bit and neither detector nor debug holding power.
    assign to_deep = ppd_q & ~lvd_hold & ~dbg_en; // R9 R12 R21
    assign cmd_bg = cmd_valid_i && cmd == CMD_BACKGROUND;
    assign dbg_req = debug_halt_instr_i | ctrl_bkpt_i | trig_bkpt_i | cmd_bg; // R2
    assign cmd_go = cmd_valid_i && cmd == CMD_GO && mode_q == ST_DEBUG; // R5
    // In deep stop the interrupt pin is always active low.
    assign irq_active = (mode_q == ST_DEEP) ? ~irq_pin_s
                      : (opt_q[OPT_IRQHI_BIT] ? irq_pin_s : ~irq_pin_s); // R14
    // Config registers return to defaults on any device reset, deep wake included.
    assign sys_reset = rst_i | (mode_q == ST_RESET); // R15

    always_comb begin
        mode_d = mode_q;
        illegal_d = 1'b0;
        intwake_d = 1'b0;
        if (!rst_pin_s) begin
            mode_d = ST_RESET; // R14 R19
        end else begin
            unique case (mode_q)
                ST_RESET: begin
                    mode_d = ms_pin_s ? ST_RUN : ST_DEBUG; // R1 R2
                end
                ST_RUN: begin
                    if (dbg_req) begin
                        mode_d = ST_DEBUG; // R2
                    end else if (halt_instr_i) begin
                        if (!permit) begin
                            mode_d = ST_RESET; // R7
                            illegal_d = 1'b1;
                        end else begin
                            mode_d = to_deep ? ST_DEEP : ST_LIGHT; // R6 R8
                        end
                    end
                end
                ST_DEBUG: begin
                    if (cmd_go) begin
                        mode_d = ST_RUN; // R5
                    end
                end
                ST_DEEP: begin
                    if (irq_active || rti_hit) begin
                        mode_d = ST_RESET; // R14 R15
                    end
                end
                ST_LIGHT: begin
                    if (cmd_bg && dbg_en) begin
                        mode_d = ST_DEBUG;
                    end else if (irq_active || rti_hit || lvd_irq_i || adc_irq_i
                                 || serial_irq_i) begin
                        mode_d = ST_RUN; // R19
                        intwake_d = 1'b1;
                    end
                end
                default: begin
                    mode_d = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= ST_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Outputs follow the next mode so they line up with mode_q.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_run_o <= 1'b0;
            cpu_suspend_o <= 1'b0;
            periph_reset_o <= 1'b1;
            reset_fetch_o <= 1'b0;
            vector_o <= 16'h0000;
            int_wake_o <= 1'b0;
            illegal_reset_o <= 1'b0;
            clocks_halt_o <= 1'b0;
            debug_clk_keep_o <= 1'b0;
            logic_power_off_o <= 1'b0;
            regulator_standby_o <= 1'b0;
            clk_gen_off_o <= 1'b0;
            osc_keep_o <= 1'b0;
            adc_disable_o <= 1'b0;
        end else begin
            cpu_run_o <= mode_d == ST_RUN;
            cpu_suspend_o <= mode_d == ST_DEBUG; // R3
            periph_reset_o <= mode_d == ST_RESET;
            reset_fetch_o <= mode_q == ST_RESET && mode_d == ST_RUN; // R1
            vector_o <= RESET_VECTOR;
            int_wake_o <= intwake_d;
            illegal_reset_o <= illegal_d;
            clocks_halt_o <= mode_d == ST_DEEP || mode_d == ST_LIGHT; // R6
            debug_clk_keep_o <= mode_d == ST_LIGHT && dbg_en; // R21
            logic_power_off_o <= mode_d == ST_DEEP; // R10
            regulator_standby_o <= mode_d == ST_DEEP
                || (mode_d == ST_LIGHT && !dbg_en && !lvd_hold); // R10 R11 R12
            clk_gen_off_o <= mode_d == ST_DEEP
                || (mode_d == ST_LIGHT && !opt_q[OPT_OSCKEEP_BIT] && !dbg_en); // R11
            osc_keep_o <= mode_d == ST_LIGHT && (opt_q[OPT_OSCKEEP_BIT] || dbg_en);
            adc_disable_o <= mode_d == ST_DEEP; // R10
        end
    end

    // Debug commands answer one cycle after cmd_valid_i.
    always_comb begin
        unique case (cmd)
            CMD_MEM, CMD_MEM_STAT, CMD_CTRL_REG, CMD_BACKGROUND: begin
                cmd_ok = mode_q == ST_RUN || mode_q == ST_DEBUG; // R4
            end
            CMD_CPU_REG, CMD_TRACE, CMD_GO: begin
                cmd_ok = mode_q == ST_DEBUG; // R5
            end
            CMD_SPARE: begin
                cmd_ok = 1'b0;
            end
        endcase
        if (cmd == CMD_BACKGROUND && mode_q == ST_LIGHT && dbg_en) begin
            cmd_ok = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_done_o <= 1'b0;
            cmd_error_o <= 1'b0;
            trace_step_o <= 1'b0;
        end else begin
            cmd_done_o <= cmd_valid_i;
            cmd_error_o <= cmd_valid_i && !cmd_ok; // R5
            trace_step_o <= cmd_valid_i && cmd == CMD_TRACE && mode_q == ST_DEBUG;
        end
    end

    // Wake timer counts slow oscillator ticks; it stays off when the select is zero.
    // The edge register resets to the synchroniser's reset level, so no false edge follows reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_q <= 1'b1;
            tick_cnt_q <= '0;
            wake_osc_en_o <= 1'b0;
        end else begin
            tick_q <= tick_s;
            wake_osc_en_o <= wps_q != WPS_RESET; // R20
            if (wps_q == WPS_RESET || rti_hit) begin
                tick_cnt_q <= '0;
            end else if (tick_s && !tick_q) begin
                tick_cnt_q <= tick_cnt_q + 1'b1;
            end
        end
    end
    assign rti_hit = wps_q != WPS_RESET && tick_s && !tick_q
        && tick_cnt_q == (WAKE_BASE_TICKS << (wps_q - 1'b1)) - 1'b1; // R20

    // Register writes.
    assign wr_pmc2 = cyc_i && stb_i && we_i && !ack_o && adr_i == ADDR_PMC2 && sel_i[0];
    assign ack_one = wr_pmc2 && dat_i[PMC2_ACK_BIT];

    always_ff @(posedge clk_i) begin
        if (sys_reset) begin
            opt_q <= OPT_RESET;
            wps_q <= WPS_RESET;
            ppd_q <= PPD_RESET;
        end else if (cyc_i && stb_i && we_i && !ack_o) begin
            if (adr_i == ADDR_OPT && sel_i[0]) begin
                opt_q <= dat_i[7:0];
            end
            if (adr_i == ADDR_OPT && sel_i[1]) begin
                wps_q <= dat_i[OPT_WPS_LSB +: WPS_W];
            end
            if (wr_pmc2) begin
                ppd_q <= dat_i[PMC2_PPD_BIT];
            end
        end
    end

    // Pin latch and wake flag survive device resets; only the bus reset or an acknowledge while latched clears them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            if (ack_one && latch_q) begin
                latch_q <= 1'b0; // R13 R22
                flag_q <= 1'b0; // R16
            end
            if (mode_q != ST_DEEP && mode_d == ST_DEEP) begin
                latch_q <= 1'b1; // R13
            end
            if (mode_q == ST_DEEP && mode_d != ST_DEEP) begin
                flag_q <= 1'b1; // R16
            end
        end
    end

    // Software must restore the port registers before acknowledging.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_q_init: pins_o <= '0;
            pin_latch_o <= 1'b0;
        end else begin
            pin_latch_o <= latch_q;
            if (!latch_q) begin
                pins_o <= port_value_i; // R17 R18
            end
        end
    end

    // Bus answer one cycle after the request; unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= 32'h0000_0000;
            if (cyc_i && stb_i && !we_i && !ack_o) begin
                unique case (adr_i)
                    ADDR_PMC2: begin
                        dat_o[PMC2_PPD_BIT] <= ppd_q;
                        dat_o[PMC2_FLAG_BIT] <= flag_q;
                    end
                    ADDR_OPT: begin
                        dat_o[7:0] <= opt_q;
                        dat_o[OPT_WPS_LSB +: WPS_W] <= wps_q;
                    end
                    ADDR_STAT: begin
                        dat_o[2:0] <= mode_q;
                        dat_o[STAT_LATCH_BIT] <= latch_q;
                        dat_o[STAT_RUN_BIT] <= cpu_run_o;
                    end
                    default: begin
                        dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    sequence s_halt_ok;
        mode_q == ST_RUN && rst_pin_s && !dbg_req && halt_instr_i && permit;
    endsequence
    sequence s_deep_exit;
        mode_q == ST_DEEP && rst_pin_s && (irq_active || rti_hit);
    endsequence

    property p_run_entry;
        @(posedge clk_i) disable iff (rst_i)
        mode_q == ST_RESET && rst_pin_s && ms_pin_s |=> mode_q == ST_RUN && reset_fetch_o
            && vector_o == 16'hFFFE;
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("run entry wrong"); // R1
    property p_debug_entry;
        @(posedge clk_i) disable iff (rst_i)
        mode_q == ST_RUN && rst_pin_s && dbg_req |=> cpu_suspend_o && !cpu_run_o;
    endproperty
    a_debug_entry: assert property (p_debug_entry) else $error("debug entry missed"); // R2 R3
    property p_active_cmd_in_run;
        @(posedge clk_i) disable iff (rst_i)
        cmd_valid_i && mode_q == ST_RUN && (cmd == CMD_GO || cmd == CMD_TRACE)
            |=> cmd_error_o && !trace_step_o;
    endproperty
    a_active_cmd_in_run: assert property (p_active_cmd_in_run) else $error("cmd ran"); // R5
    property p_mem_cmd_ok;
        @(posedge clk_i) disable iff (rst_i)
        cmd_valid_i && cmd == CMD_MEM && (mode_q == ST_RUN || mode_q == ST_DEBUG)
            |=> cmd_done_o && !cmd_error_o;
    endproperty
    a_mem_cmd_ok: assert property (p_mem_cmd_ok) else $error("mem cmd refused"); // R4
    property p_illegal;
        @(posedge clk_i) disable iff (rst_i)
        mode_q == ST_RUN && rst_pin_s && !dbg_req && halt_instr_i && !permit
            |=> illegal_reset_o && periph_reset_o ##1 !illegal_reset_o;
    endproperty
    a_illegal: assert property (p_illegal) else $error("no illegal reset"); // R7
    property p_stop_select;
        @(posedge clk_i) disable iff (rst_i)
        s_halt_ok |=> clocks_halt_o && (logic_power_off_o == $past(to_deep));
    endproperty
    a_stop_select: assert property (p_stop_select) else $error("stop select"); // R9 R12
    property p_pins_held;
        @(posedge clk_i) disable iff (rst_i)
        pin_latch_o && $past(pin_latch_o) |-> $stable(pins_o);
    endproperty
    a_pins_held: assert property (p_pins_held) else $error("pins moved"); // R13
    property p_wake_flag;
        @(posedge clk_i) disable iff (rst_i)
        s_deep_exit |=> periph_reset_o && flag_q && latch_q;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("deep wake"); // R15 R16
    property p_ack_noop;
        @(posedge clk_i) disable iff (rst_i)
        wr_pmc2 && (!dat_i[PMC2_ACK_BIT] || !latch_q) && mode_q != ST_DEEP
            |=> flag_q == $past(flag_q);
    endproperty
    a_ack_noop: assert property (p_ack_noop) else $error("ack had effect"); // R22
    property p_timer_off;
        @(posedge clk_i) disable iff (rst_i)
        wps_q == WPS_RESET [*2] |-> !wake_osc_en_o && !rti_hit;
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("timer on"); // R20
endmodule

/* verilog/opmode_pkg.sv */
// Constants, register map and types shared by the operating mode sequencer.
package opmode_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] ADDR_PMC2 = 8'h00;
    localparam logic [7:0] ADDR_OPT = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    // Power management control 2 field positions.
    localparam int PMC2_PPD_BIT = 0;
    localparam int PMC2_ACK_BIT = 1;
    localparam int PMC2_FLAG_BIT = 3;
    // Option register field positions.
    localparam int OPT_PERMIT_BIT = 0;
    localparam int OPT_LOWVOLT_DETECT_EN_BIT = 1;
    localparam int OPT_LOWVOLT_IN_HALT_EN_BIT = 2;
    localparam int OPT_DBGEN_BIT = 3;
    localparam int OPT_OSCKEEP_BIT = 4;
    localparam int OPT_IRQHI_BIT = 5;
    localparam int OPT_WPS_LSB = 8;
    localparam int WPS_W = 3;
    // Status register field positions.
    localparam int STAT_LATCH_BIT = 3;
    localparam int STAT_RUN_BIT = 4;
    // Values after reset.
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [WPS_W-1:0] WPS_RESET = 3'h0;
    localparam logic PPD_RESET = 1'b0;
    // Start vector fetched after a reset into normal run.
    localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
    // Wake timer: slow oscillator ticks per period for select value 1.
    localparam int WAKE_TICK_W = 11;
    localparam logic [WAKE_TICK_W-1:0] WAKE_BASE_TICKS = 11'h008;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_DEBUG,
        ST_DEEP,
        ST_LIGHT
    } mode_t;

    typedef enum logic [2:0] {
        CMD_MEM,
        CMD_MEM_STAT,
        CMD_CTRL_REG,
        CMD_BACKGROUND,
        CMD_CPU_REG,
        CMD_TRACE,
        CMD_GO,
        CMD_SPARE
    } cmd_t;
endpackage

/* verilog/pin_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous input and synchronised output.
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
